// ---- include/pfcv_defs.svh ----
/*
 * Constants of the input-threshold and output-overvoltage register block:
 * command codes, field positions, reset values and fault timing.
 * Assumes it is included by the package and the design modules only.
 */
`ifndef PFCV_DEFS_SVH
`define PFCV_DEFS_SVH

// Command codes as seen on the management bus
`define PFCV_CMD_CLEAR_FAULTS 8'h03
`define PFCV_REG_VIN_START 8'h35
`define PFCV_REG_VIN_STOP 8'h36
`define PFCV_REG_OV_LIMIT 8'h40
`define PFCV_REG_OV_ACTION 8'h41

// Linear format widths and field positions
`define PFCV_MANT_W 11
`define PFCV_EXP_W 5
`define PFCV_EXP_LSB 11
`define PFCV_EXP_MSB 15
`define PFCV_MANT_MSB 10
`define PFCV_CFG_EXP_W 3
`define PFCV_DATA_W 16
`define PFCV_ACT_W 8
`define PFCV_WIDE_W 42

// Fault action register fields
`define PFCV_ACT_CODE_MSB 7
`define PFCV_ACT_CODE_LSB 6
`define PFCV_ACT_RETRY_MSB 5
`define PFCV_ACT_RETRY_LSB 3
`define PFCV_ACT_DLY_MSB 2
`define PFCV_ACT_DLY_LSB 0
`define PFCV_RETRY_FOREVER 3'h7

// Reset values
`define PFCV_RST_MANT 11'h000
`define PFCV_RST_ACT 8'h00

// Timing: clock rate and the delay pairs in milliseconds
`define PFCV_CLK_KHZ 100000
`define PFCV_DT1_A_MS 10
`define PFCV_DT1_B_MS 20
`define PFCV_DT1_C_MS 40
`define PFCV_DT2_A_MS 252
`define PFCV_DT2_B_MS 558
`define PFCV_DT2_C_MS 924

`endif

// ---- include/pfcv_pkg.sv ----
/*
 * Types of the threshold and overvoltage fault block.
 * Assumes pfcv_defs.svh is on the include path.
 */
`include "pfcv_defs.svh"

package pfcv_pkg;

    // Linear value: Y times 2 to the N, N in twos complement
    typedef struct packed {
        logic signed [`PFCV_EXP_W-1:0] exp;
        logic [`PFCV_MANT_W-1:0] mant;
    } pfcv_lin_t;

    typedef enum logic [1:0] {CMD_SEND, CMD_WRITE, CMD_READ} pfcv_cmd_kind_t;

    // One decoded host transaction, valid for one cycle
    typedef struct packed {
        logic valid;
        pfcv_cmd_kind_t kind;
        logic [7:0] code;
        logic [`PFCV_DATA_W-1:0] data;
    } pfcv_cmd_t;

    // Action codes in bits 7:6 of the fault action register
    typedef enum logic [1:0] {ACT_IGNORE, ACT_DELAY_RETRY, ACT_SHUT_RETRY, ACT_HOLD_OFF}
        pfcv_act_t;

    typedef enum logic [2:0] {ST_RUN, ST_DELAY1, ST_RETRY_WAIT, ST_HOLD, ST_LATCHED}
        pfcv_fsm_t;

    // Whole state of the main module
    typedef struct packed {
        pfcv_fsm_t state;
        logic [31:0] tmr;
        logic [2:0] retries;
        logic out_en;
        logic conv_on;
        logic ov_flag;
        logic rd_valid;
        logic [`PFCV_DATA_W-1:0] rd_data;
        logic [`PFCV_MANT_W-1:0] vin_start;
        logic [`PFCV_MANT_W-1:0] vin_stop;
        logic [`PFCV_MANT_W-1:0] ov_limit;
        logic [`PFCV_ACT_W-1:0] action;
    } pfcv_state_t;

endpackage

// ---- logic/pfcv_lin_cmp.sv ----
/*
 * Compares two linear-format values (mantissa times two to a signed
 * exponent) after bringing both onto one fixed-point scale.
 * Purely combinational; caller registers the result if needed.
 */
`timescale 1ns/1ns
`include "pfcv_defs.svh"

module pfcv_lin_cmp (
    // Operands
    input wire pfcv_pkg::pfcv_lin_t i_a,
    input wire pfcv_pkg::pfcv_lin_t i_b,
    // Result
    output logic o_a_ge_b
);
    import pfcv_pkg::*;

    // Offset-binary exponent gives a shift of 0..31, so -16 maps to no shift
    function automatic logic [`PFCV_WIDE_W-1:0] widen(input pfcv_lin_t v);
        logic [4:0] sh;
        sh = {~v.exp[4], v.exp[3:0]};
        return {{(`PFCV_WIDE_W-`PFCV_MANT_W){1'b0}}, v.mant} << sh;
    endfunction

    // Both sides share one scale so an exponent change rescales consistently
    always_comb begin
        o_a_ge_b = widen(i_a) >= widen(i_b);
    end
endmodule

// ---- logic/pfcv_fault_regs.sv ----
/*
 * Input start/stop thresholds, output overvoltage limit and the selectable
 * overvoltage fault response of a power-factor-correction controller.
 * Assumes a host engine that hands over decoded commands one cycle long,
 * exponent fields from other configuration registers, and measurements
 * already in linear format on this clock.
 */
`timescale 1ns/1ns
`include "pfcv_defs.svh"

module pfcv_fault_regs #(
    parameter int CYC_PER_MS = `PFCV_CLK_KHZ
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Host command port
    input wire pfcv_pkg::pfcv_cmd_t i_cmd,
    output logic o_rd_valid,
    output logic [`PFCV_DATA_W-1:0] o_rd_data,
    // Exponents from other configuration registers
    input wire logic [`PFCV_CFG_EXP_W-1:0] i_vin_exp,
    input wire logic [`PFCV_CFG_EXP_W-1:0] i_vout_exp,
    // Measurements
    input wire logic [`PFCV_MANT_W-1:0] i_vin_meas,
    input wire pfcv_pkg::pfcv_lin_t i_vout_meas,
    // Power stage control and status
    output logic o_conv_on,
    output logic o_out_en,
    output logic o_ov_flag
);
    import pfcv_pkg::*;

    localparam pfcv_state_t RST_STATE = '{
        state: ST_RUN, tmr: 32'h0000_0000, retries: 3'h0, out_en: 1'b1,
        conv_on: 1'b0, ov_flag: 1'b0, rd_valid: 1'b0, rd_data: 16'h0000,
        vin_start: `PFCV_RST_MANT, vin_stop: `PFCV_RST_MANT,
        ov_limit: `PFCV_RST_MANT, action: `PFCV_RST_ACT};

    pfcv_state_t q;
    pfcv_state_t d;
    pfcv_lin_t vin_lin;
    pfcv_lin_t start_lin;
    pfcv_lin_t stop_lin;
    pfcv_lin_t lim_lin;
    logic vin_ge_start;
    logic stop_ge_vin;
    logic lim_ge_vout;
    logic ov_now;
    logic clr_faults;
    logic [`PFCV_EXP_W-1:0] vin_exp5;
    logic [`PFCV_EXP_W-1:0] vout_exp5;
    pfcv_act_t act;
    logic [2:0] retry_lim;
    logic [2:0] dly_sel;

    // Three-bit twos complement exponent widened to the five-bit field
    function automatic logic [`PFCV_EXP_W-1:0] sext_exp(input logic [2:0] e);
        return {{(`PFCV_EXP_W-`PFCV_CFG_EXP_W){e[2]}}, e};
    endfunction

    // Delay table; codes above 010 reuse the longest pair
    function automatic logic [31:0] dly_cycles(input logic [2:0] sel, input logic second);
        int ms;
        ms = second ? `PFCV_DT2_C_MS : `PFCV_DT1_C_MS;
        case (sel)
            3'h0: ms = second ? `PFCV_DT2_A_MS : `PFCV_DT1_A_MS;
            3'h1: ms = second ? `PFCV_DT2_B_MS : `PFCV_DT1_B_MS;
            default: ms = second ? `PFCV_DT2_C_MS : `PFCV_DT1_C_MS;
        endcase
        return 32'(ms * CYC_PER_MS);
    endfunction

    // Exponents are mirrored live, never stored here
    always_comb begin
        vin_exp5 = sext_exp(i_vin_exp);
        vout_exp5 = sext_exp(i_vout_exp);
        vin_lin = '{exp: vin_exp5, mant: i_vin_meas};
        start_lin = '{exp: vin_exp5, mant: q.vin_start};
        stop_lin = '{exp: vin_exp5, mant: q.vin_stop};
        lim_lin = '{exp: vout_exp5, mant: q.ov_limit};
    end

    // Threshold comparators on a common scale
    pfcv_lin_cmp u_cmp_start (
        .i_a(vin_lin),
        .i_b(start_lin),
        .o_a_ge_b(vin_ge_start)
    );

    pfcv_lin_cmp u_cmp_stop (
        .i_a(stop_lin),
        .i_b(vin_lin),
        .o_a_ge_b(stop_ge_vin)
    );

    pfcv_lin_cmp u_cmp_ov (
        .i_a(lim_lin),
        .i_b(i_vout_meas),
        .o_a_ge_b(lim_ge_vout)
    );

    // Decoded events and action fields
    always_comb begin
        ov_now = !lim_ge_vout;
        clr_faults = i_cmd.valid && i_cmd.kind == CMD_SEND
            && i_cmd.code == `PFCV_CMD_CLEAR_FAULTS;
        act = pfcv_act_t'(q.action[`PFCV_ACT_CODE_MSB:`PFCV_ACT_CODE_LSB]);
        retry_lim = q.action[`PFCV_ACT_RETRY_MSB:`PFCV_ACT_RETRY_LSB];
        dly_sel = q.action[`PFCV_ACT_DLY_MSB:`PFCV_ACT_DLY_LSB];
    end

    // Output off after a fault: retry while attempts remain, else latch off
    function automatic pfcv_state_t shut_off(input pfcv_state_t s, input logic [2:0] lim,
                                             input logic [2:0] sel);
        pfcv_state_t r;
        r = s;
        r.out_en = 1'b0;
        if (lim == `PFCV_RETRY_FOREVER || s.retries != lim) begin
            r.state = ST_RETRY_WAIT;
            r.tmr = dly_cycles(sel, 1'b1) - 32'd1;
        end else begin
            r.state = ST_LATCHED;
        end
        return r;
    endfunction

    // Next-state logic for registers, thresholds and the fault sequencer
    always_comb begin
        d = q;
        d.rd_valid = 1'b0;

        // Start wins when both thresholds are met, so a bad setting still runs
        if (vin_ge_start) begin
            d.conv_on = 1'b1;
        end else if (stop_ge_vin) begin
            d.conv_on = 1'b0;
        end

        // Host writes and reads; unmapped codes read as zero
        if (i_cmd.valid && i_cmd.kind == CMD_WRITE) begin
            case (i_cmd.code)
                `PFCV_REG_VIN_START: d.vin_start = i_cmd.data[`PFCV_MANT_MSB:0];
                `PFCV_REG_VIN_STOP: d.vin_stop = i_cmd.data[`PFCV_MANT_MSB:0];
                `PFCV_REG_OV_LIMIT: d.ov_limit = i_cmd.data[`PFCV_MANT_MSB:0];
                `PFCV_REG_OV_ACTION: d.action = i_cmd.data[`PFCV_ACT_W-1:0];
                default: d.action = q.action;
            endcase
        end
        if (i_cmd.valid && i_cmd.kind == CMD_READ) begin
            d.rd_valid = 1'b1;
            case (i_cmd.code)
                `PFCV_REG_VIN_START: d.rd_data = {vin_exp5, q.vin_start};
                `PFCV_REG_VIN_STOP: d.rd_data = {vin_exp5, q.vin_stop};
                `PFCV_REG_OV_LIMIT: d.rd_data = {vout_exp5, q.ov_limit};
                `PFCV_REG_OV_ACTION: d.rd_data = {8'h00, q.action};
                default: d.rd_data = 16'h0000;
            endcase
        end

        // Sticky fault bit; a new fault in the clearing cycle is kept
        if (ov_now) begin
            d.ov_flag = 1'b1;
        end else if (clr_faults) begin
            d.ov_flag = 1'b0;
        end

        case (q.state)
            ST_RUN: begin
                if (ov_now) begin
                    case (act)
                        ACT_IGNORE: d.state = ST_RUN;
                        ACT_DELAY_RETRY: begin
                            d.state = ST_DELAY1;
                            d.tmr = dly_cycles(dly_sel, 1'b0) - 32'd1;
                        end
                        ACT_SHUT_RETRY: d = shut_off(d, retry_lim, dly_sel);
                        ACT_HOLD_OFF: begin
                            d.out_en = 1'b0;
                            d.state = ST_HOLD;
                        end
                        default: d.state = ST_RUN;
                    endcase
                end
            end
            ST_DELAY1: begin
                // Output keeps running through delay 1
                if (q.tmr != 32'd0) begin
                    d.tmr = q.tmr - 32'd1;
                end else if (ov_now) begin
                    d = shut_off(d, retry_lim, dly_sel);
                end else begin
                    d.state = ST_RUN;
                end
            end
            ST_RETRY_WAIT: begin
                if (q.tmr != 32'd0) begin
                    d.tmr = q.tmr - 32'd1;
                end else begin
                    d.out_en = 1'b1;
                    d.state = ST_RUN;
                    if (retry_lim != `PFCV_RETRY_FOREVER) begin
                        d.retries = q.retries + 3'd1;
                    end
                end
            end
            ST_HOLD: begin
                if (!ov_now) begin
                    d.out_en = 1'b1;
                    d.state = ST_RUN;
                end
            end
            ST_LATCHED: begin
                d.out_en = 1'b0;
            end
            default: d.state = ST_RUN;
        endcase

        // Clear faults releases a latched output and restarts the retry budget
        if (clr_faults) begin
            d.retries = 3'h0;
            if (q.state == ST_LATCHED) begin
                d.state = ST_RUN;
                d.out_en = 1'b1;
            end
        end
    end

    // Single state register
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    always_comb begin
        o_rd_valid = q.rd_valid;
        o_rd_data = q.rd_data;
        o_conv_on = q.conv_on;
        o_out_en = q.out_en;
        o_ov_flag = q.ov_flag;
    end

    a_conv_start_on: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        vin_ge_start |=> o_conv_on) else $error("conversion not started");

    a_conv_stop_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (!vin_ge_start && stop_ge_vin) |=> !o_conv_on)
        else $error("conversion not stopped");

    a_vin_exp_mirror: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_cmd.valid && i_cmd.kind == CMD_READ && i_cmd.code == `PFCV_REG_VIN_START)
        |=> o_rd_valid && o_rd_data[`PFCV_EXP_MSB:`PFCV_EXP_LSB]
            == sext_exp($past(i_vin_exp))) else $error("input exponent mismatch");

    a_ov_exp_mirror: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_cmd.valid && i_cmd.kind == CMD_READ && i_cmd.code == `PFCV_REG_OV_LIMIT)
        |=> o_rd_data[`PFCV_EXP_MSB:`PFCV_EXP_LSB]
            == sext_exp($past(i_vout_exp))) else $error("output exponent mismatch");

    a_ov_flag_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        ov_now |=> o_ov_flag) else $error("fault flag not set");

    // Equal exponents must reduce the scaled compare to a plain mantissa compare
    a_ov_same_scale: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (i_vout_meas.exp == vout_exp5) |-> ov_now == (i_vout_meas.mant > q.ov_limit))
        else $error("same scale compare wrong");

    a_ignore_keeps_on: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (q.state == ST_RUN && act == ACT_IGNORE && !clr_faults) |=> o_out_en)
        else $error("ignore code disabled output");

    a_delay1_runs: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (q.state == ST_RUN && ov_now && act == ACT_DELAY_RETRY) |=> o_out_en [*2])
        else $error("output dropped inside delay 1");

    a_shut_immediate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (q.state == ST_RUN && ov_now && act == ACT_SHUT_RETRY) |=> !o_out_en)
        else $error("output not shut down");

    // Unlimited retries never count down, so a shut-off always leads to another wait
    a_forever_no_latch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (q.state == ST_RUN && ov_now && act == ACT_SHUT_RETRY
            && retry_lim == `PFCV_RETRY_FOREVER) |=> q.state == ST_RETRY_WAIT)
        else $error("unlimited retries latched");

    a_hold_reenable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (q.state == ST_HOLD && !ov_now) |=> o_out_en) else $error("no re-enable");

    a_latched_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (q.state == ST_LATCHED && !clr_faults) |=> !o_out_en) else $error("latch leaked");

    a_clear_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (clr_faults && !ov_now) |=> !o_ov_flag) else $error("flag not cleared");
endmodule

// ---- dv/pfcv_host.sv ----
/*
 * Host model for the threshold and fault block: issues send, write and
 * read commands one cycle long and collects read answers.
 * Assumes the design takes a command on the rising edge after it is set.
 */
`timescale 1ns/1ns

module pfcv_host (
    // Clock
    input wire logic i_ref_clk,
    // Read answer from the device
    input wire logic i_rd_valid,
    input wire logic [15:0] i_rd_data,
    // Command to the device
    output pfcv_pkg::pfcv_cmd_t o_cmd
);
    import pfcv_pkg::*;

    initial o_cmd = '0;

    // Drive off the sampling edge; idle data is scrambled so stale bits never count
    task automatic issue(input pfcv_cmd_kind_t k, input logic [7:0] c, input logic [15:0] d);
        @(negedge i_ref_clk);
        o_cmd <= {1'b1, k, c, d};
        @(negedge i_ref_clk);
        o_cmd.valid <= 1'b0;
        o_cmd.data <= ~d;
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        issue(CMD_WRITE, c, d);
    endtask

    // Fault clear takes no data byte
    task automatic send(input logic [7:0] c);
        issue(CMD_SEND, c, 16'h0000);
    endtask

    // Answer stands from the taking edge; captured at the falling edge after it
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
        issue(CMD_READ, c, 16'h0000);
        d = i_rd_data;
        v = i_rd_valid;
    endtask
endmodule

// ---- dv/tb.sv ----
/*
 * Self-checking bench of the threshold and overvoltage fault block.
 * Assumes a 100 MHz clock and a short millisecond count for the delays.
 */
`timescale 1ns/1ns

`define CHK(nm, e, g) \
    begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end

module tb;
    import pfcv_pkg::*;

    localparam int CPM = 2;
    localparam int LIMIT = 6000;
    logic i_ref_clk = 1'b0;
    logic rst_b = 1'b0;
    pfcv_cmd_t cmd;
    logic rd_valid, conv_on, out_en, ov_flag;
    logic [15:0] rd_data;
    logic [2:0] vin_exp = 3'h5;
    logic [2:0] vout_exp = 3'h2;
    logic [10:0] vin_meas = 11'h000;
    pfcv_lin_t vout_meas = '0;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    pfcv_fault_regs #(.CYC_PER_MS(CPM)) dut (
        .i_ref_clk(i_ref_clk), .i_rst_b(rst_b), .i_cmd(cmd),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .i_vin_exp(vin_exp), .i_vout_exp(vout_exp),
        .i_vin_meas(vin_meas), .i_vout_meas(vout_meas),
        .o_conv_on(conv_on), .o_out_en(out_en), .o_ov_flag(ov_flag)
    );

    pfcv_host host (
        .i_ref_clk(i_ref_clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_cmd(cmd)
    );

    // Clock, 10 ns period
    always #5 i_ref_clk = ~i_ref_clk;

    // Hang guard
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask

    // Readback of every register, exponent fields read-only
    task automatic sc_regs();
        logic [15:0] d;
        logic v;
        host.rd(8'h35, d, v);
        `CHK("rd_valid", 1'b1, v);
        `CHK("start rst", {5'h1D, 11'h000}, d);
        host.wr(8'h35, 16'hFFFF);
        host.rd(8'h35, d, v);
        `CHK("start", {5'h1D, 11'h7FF}, d);
        host.wr(8'h36, 16'h0123);
        host.rd(8'h36, d, v);
        `CHK("stop", {5'h1D, 11'h123}, d);
        host.wr(8'h40, 16'hA5A5);
        host.rd(8'h40, d, v);
        `CHK("limit", {5'h02, 11'h5A5}, d);
        host.wr(8'h41, 16'hFF9C);
        host.rd(8'h41, d, v);
        `CHK("action", 16'h009C, d);
        host.rd(8'h50, d, v);
        `CHK("unmapped", 16'h0000, d);
    endtask

    // Start and stop thresholds give hysteresis
    task automatic sc_thresh();
        vin_exp = 3'h0;
        host.wr(8'h35, 16'h0064);
        host.wr(8'h36, 16'h0032);
        vin_meas = 11'd40;
        wait_n(3);
        `CHK("conv low", 1'b0, conv_on);
        vin_meas = 11'd99;
        wait_n(3);
        `CHK("conv below start", 1'b0, conv_on);
        vin_meas = 11'd100;
        wait_n(2);
        `CHK("conv at start", 1'b1, conv_on);
        vin_meas = 11'd51;
        wait_n(3);
        `CHK("conv above stop", 1'b1, conv_on);
        vin_meas = 11'd50;
        wait_n(2);
        `CHK("conv at stop", 1'b0, conv_on);
    endtask

    // Code 00: flag only; limit equality is no fault
    task automatic sc_ignore();
        vout_exp = 3'h0;
        host.wr(8'h40, 16'h00C8);
        host.wr(8'h41, 16'h0000);
        vout_meas = {5'h00, 11'd200};
        wait_n(3);
        `CHK("flag at limit", 1'b0, ov_flag);
        vout_meas = {5'h01, 11'd101};
        wait_n(2);
        `CHK("flag scaled", 1'b1, ov_flag);
        `CHK("out ignore", 1'b1, out_en);
        vout_meas = {5'h00, 11'd100};
        host.send(8'h03);
        wait_n(1);
        `CHK("flag clear", 1'b0, ov_flag);
    endtask

    // Code 10, one retry, shortest delay pair
    task automatic sc_shut();
        host.wr(8'h41, 16'h0088);
        vout_meas = {5'h00, 11'd201};
        wait_n(1);
        `CHK("out shut", 1'b0, out_en);
        vout_meas = {5'h00, 11'd100};
        wait_n(252 * CPM - 4);
        `CHK("out retry wait", 1'b0, out_en);
        wait_n(8);
        `CHK("out retried", 1'b1, out_en);
        vout_meas = {5'h00, 11'd201};
        wait_n(2);
        vout_meas = {5'h00, 11'd100};
        wait_n(252 * CPM + 16);
        `CHK("out latched", 1'b0, out_en);
        host.send(8'h03);
        wait_n(3);
        `CHK("out released", 1'b1, out_en);
    endtask

    // Code 10 with retry field 7: a second fault waits again instead of latching
    task automatic sc_forever();
        host.wr(8'h41, 16'h00B8);
        vout_meas = {5'h00, 11'd201};
        wait_n(1);
        `CHK("out shut forever", 1'b0, out_en);
        vout_meas = {5'h00, 11'd100};
        wait_n(252 * CPM + 4);
        `CHK("out retry 1", 1'b1, out_en);
        vout_meas = {5'h00, 11'd201};
        wait_n(2);
        `CHK("out shut again", 1'b0, out_en);
        vout_meas = {5'h00, 11'd100};
        wait_n(252 * CPM + 4);
        `CHK("out retry 2", 1'b1, out_en);
        host.send(8'h03);
    endtask

    // Code 11 follows the fault
    task automatic sc_hold();
        host.wr(8'h41, 16'h00C0);
        vout_meas = {5'h00, 11'd201};
        wait_n(2);
        `CHK("out hold", 1'b0, out_en);
        wait_n(30);
        `CHK("out still held", 1'b0, out_en);
        vout_meas = {5'h00, 11'd100};
        wait_n(3);
        `CHK("out back", 1'b1, out_en);
        host.send(8'h03);
    endtask

    // Code 01 runs on for delay 1, then with no retries stays off
    task automatic sc_delay(input logic [2:0] sel, input int dt1);
        host.wr(8'h41, {8'h00, 2'b01, 3'b000, sel});
        vout_meas = {5'h00, 11'd201};
        wait_n(dt1 * CPM - 3);
        `CHK("out during delay", 1'b1, out_en);
        wait_n(6);
        `CHK("out after delay", 1'b0, out_en);
        vout_meas = {5'h00, 11'd100};
        host.send(8'h03);
        wait_n(3);
        `CHK("out after clear", 1'b1, out_en);
    endtask

    // Reset, then every scenario in turn
    initial begin
        wait_n(4);
        `CHK("out rst", 1'b1, out_en);
        `CHK("conv rst", 1'b0, conv_on);
        `CHK("flag rst", 1'b0, ov_flag);
        `CHK("rdv rst", 1'b0, rd_valid);
        rst_b = 1'b1;
        sc_regs();
        sc_thresh();
        sc_ignore();
        sc_shut();
        sc_hold();
        sc_delay(3'h0, 10);
        sc_delay(3'h1, 20);
        sc_delay(3'h2, 40);
        sc_forever();
        final_report();
    end
endmodule
